// *** verilog/vcc_map.vh ***
// register offsets, field positions, reset values and serial frame figures of the codec control bank
// Notes on behaviour
// - address zero reads zero and writes to it change nothing
// - writing one to main_control bit 7 resets every register except the short status at address 8, then self-clears
// - main_control bit 4 one keeps both speaker drivers on, zero powers down
// - main_control bit 3 one keeps line driver on, zero powers down
// - main_control bit 2 one keeps handset driver on, zero powers down
// - main_control bit 1 one powers mic bias buffer down
// - main_control bit 0 one puts the whole device to sleep
// - filter_loopback_control bit 4 one disables the receive high-pass filter
// - filter_loopback_control bit 3 selects final PLL divide by 10, else 5
// - filter_loopback_control bit 2 loops converter analog output to input
// - filter_loopback_control bit 1 loops one-bit modulator stream to input converter
// - divider and multiplier registers give effective factor value plus one
// - register five bits 7:6 line gain, bit 5 line mute
// - register five bits 4:3 mic gain, bit 2 mic mute
// - register five bit 1 mutes handset input
// - register five bit 0 selects recursive filter, zero selects FIR
// - register six bits 6:2 hold receive gain code, 1.5 dB steps
// - register six bit 1 line output active, bit 0 handset output active
// - register five resets to 0100_0111
// - frame: read/write bit, 5-bit address, 8 data bits
// - both PLL registers zero means PLL bypass
// - sleep left only by reset pin pulse, master clock running
`ifndef VCC_MAP_VH
`define VCC_MAP_VH
`define VCC_ADDR_ZERO      5'h00
`define VCC_ADDR_MAIN      5'h01
`define VCC_ADDR_FILT      5'h02
`define VCC_ADDR_PDIV      5'h03
`define VCC_ADDR_PMUL      5'h04
`define VCC_ADDR_INGAIN    5'h05
`define VCC_ADDR_RXVOL     5'h06
`define VCC_ADDR_TXVOL     5'h07
`define VCC_ADDR_SHORT     5'h08
`define VCC_ADDR_ATTEN     5'h09
`define VCC_RST_MAIN       8'h00
`define VCC_RST_FILT       8'h00
`define VCC_RST_PDIV       8'h00
`define VCC_RST_PMUL       8'h00
`define VCC_RST_INGAIN     8'h47
`define VCC_RST_RXVOL      8'h5C
`define VCC_RST_TXVOL      8'h5C
`define VCC_RST_ATTEN      8'h00
`define VCC_MASK_MAIN      8'h1F
`define VCC_MASK_FILT      8'h1E
`define VCC_MASK_RXVOL     8'h7F
`define VCC_MASK_TXVOL     8'h7F
`define VCC_MASK_SHORT     8'hE0
`define VCC_MASK_ATTEN     8'h0F
`define VCC_BIT_SOFT_RESET 7
`define VCC_BIT_SPK_ON     4
`define VCC_BIT_LINE_ON    3
`define VCC_BIT_HSET_ON    2
`define VCC_BIT_MICB_OFF   1
`define VCC_BIT_SLEEP      0
`define VCC_BIT_HPF_DIS    4
`define VCC_BIT_DIV10      3
`define VCC_BIT_ALOOP      2
`define VCC_BIT_BLOOP      1
`define VCC_FINAL_DIV_HI   4'hA
`define VCC_FINAL_DIV_LO   4'h5
`define VCC_FRAME_BITS     16
`define VCC_ADDR_BITS      5
`define VCC_ADDR_DONE_CNT  5'h07
`define VCC_ANS_FIRST_CNT  5'h08
`endif

// *** verilog/vcc_frame_shift.v ***
// serial shifter: collects one 16-bit secondary frame and shifts the read answer out
`timescale 1ns/100ps
`include "vcc_map.vh"
module vcc_frame_shift #(
  parameter FRAME_BITS = `VCC_FRAME_BITS
) (
  input  wire                  core_clk,
  input  wire                  rst,
  input  wire                  bit_en,
  input  wire                  frame_start,
  input  wire                  ser_in,
  input  wire [7:0]            load_data,
  input  wire                  load_en,
  output reg                   ser_out,
  output reg  [FRAME_BITS-1:0] frame_word,
  output reg                   frame_done,
  output reg                   addr_ready
);
  reg [FRAME_BITS-1:0] shift_r;
  reg [4:0]            count_r;
  reg                  active_r;
  reg [7:0]            out_r;

  localparam integer LAST_COUNT = FRAME_BITS - 1;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_r    <= {FRAME_BITS{1'b0}};
      count_r    <= 5'h00;
      active_r   <= 1'b0;
      out_r      <= 8'h00;
      ser_out    <= 1'b0;
      frame_word <= {FRAME_BITS{1'b0}};
      frame_done <= 1'b0;
      addr_ready <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      addr_ready <= 1'b0;
      if (load_en) begin
        out_r <= load_data;
      end
      if (bit_en) begin
        if (frame_start) begin
          active_r <= 1'b1;
          count_r  <= 5'h01;
          shift_r  <= {{(FRAME_BITS-1){1'b0}}, ser_in};
          ser_out  <= 1'b0;
        end else if (active_r) begin
          shift_r <= {shift_r[FRAME_BITS-2:0], ser_in};
          count_r <= count_r + 5'h01;
          // answer bits go out in the second half of the frame, msb first
          if (count_r == `VCC_ANS_FIRST_CNT) begin
            // gap-free bits leave no spare cycle for the preload, so take the mux directly
            ser_out <= load_data[7];
            out_r   <= {load_data[6:0], 1'b0};
          end else if (count_r > `VCC_ANS_FIRST_CNT) begin
            ser_out <= out_r[7];
            out_r   <= {out_r[6:0], 1'b0};
          end else begin
            ser_out <= 1'b0;
          end
          // address field ends with the eighth bit of the frame
          if (count_r == `VCC_ADDR_DONE_CNT) begin
            addr_ready <= 1'b1;
          end
          if (count_r == LAST_COUNT[4:0]) begin
            active_r   <= 1'b0;
            frame_word <= {shift_r[FRAME_BITS-2:0], ser_in};
            frame_done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // vcc_frame_shift

// *** verilog/vcc_pll_ctrl.v ***
// decodes the stored PLL settings into effective factors and the bypass select
`timescale 1ns/100ps
`include "vcc_map.vh"
module vcc_pll_ctrl (
  input  wire [7:0] div_value,
  input  wire [7:0] mul_value,
  input  wire       div10_sel,
  output wire [8:0] div_factor,
  output wire [8:0] mul_factor,
  output wire [3:0] final_div,
  output wire       pll_bypass
);
  assign div_factor = {1'b0, div_value} + 9'h001;
  assign mul_factor = {1'b0, mul_value} + 9'h001;
  assign final_div  = div10_sel ? `VCC_FINAL_DIV_HI : `VCC_FINAL_DIV_LO;
  assign pll_bypass = (div_value == 8'h00) && (mul_value == 8'h00);
endmodule // vcc_pll_ctrl

// *** verilog/vcc_control_regs.v ***
// control register bank of the voice codec, reached through secondary serial frames
`timescale 1ns/100ps
`include "vcc_map.vh"
module vcc_control_regs (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       reset_pin_n,
  input  wire       bit_en,
  input  wire       frame_start,
  input  wire       ser_in,
  output wire       ser_out,
  input  wire [2:0] short_status,
  output wire       speaker_drive_on,
  output wire       line_drive_on,
  output wire       handset_drive_on,
  output wire       mic_bias_off,
  output wire       chip_sleep,
  output wire       highpass_disable,
  output wire       analog_loopback_en,
  output wire       bitstream_loopback_en,
  output wire [7:0] pll_div_value,
  output wire [7:0] pll_mul_value,
  output wire [8:0] pll_div_factor,
  output wire [8:0] pll_mul_factor,
  output wire [3:0] pll_final_div,
  output wire       pll_bypass,
  output wire [1:0] line_in_gain,
  output wire       line_in_mute,
  output wire [1:0] mic_gain,
  output wire       mic_mute,
  output wire       handset_in_mute,
  output wire       recursive_filter_sel,
  output wire [4:0] receive_gain_code,
  output wire       line_out_active,
  output wire       handset_out_active,
  output wire [7:0] transmit_volume,
  output wire [7:0] output_attenuation
);
  reg  [7:0]  main_control_r;
  reg  [7:0]  filter_loopback_control_r;
  reg  [7:0]  pll_divider_r;
  reg  [7:0]  pll_multiplier_r;
  reg  [7:0]  input_gain_mute_r;
  reg  [7:0]  receive_volume_r;
  reg  [7:0]  transmit_volume_r;
  reg  [7:0]  output_attenuation_r;
  reg  [7:0]  short_latch_r;
  reg         sleep_hold_r;
  wire [15:0] frame_word;
  wire        frame_done;
  wire        addr_ready;
  wire        wr_strobe;
  wire [4:0]  wr_addr;
  wire [7:0]  wr_data;
  wire        soft_reset;
  reg  [7:0]  rd_data;
  reg  [15:0] partial_r;

  // low five bits hold the address once the eighth bit is in; mux reads them directly
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      partial_r <= 16'h0000;
    end else if (bit_en) begin
      partial_r <= frame_start ? {15'h0000, ser_in} : {partial_r[14:0], ser_in};
    end
  end

  function [7:0] read_mux;
    input [4:0] addr;
    begin
      // if chain keeps the unmapped and zero addresses reading zero
      if (addr == `VCC_ADDR_MAIN) begin
        read_mux = main_control_r & `VCC_MASK_MAIN;
      end else if (addr == `VCC_ADDR_FILT) begin
        read_mux = filter_loopback_control_r & `VCC_MASK_FILT;
      end else if (addr == `VCC_ADDR_PDIV) begin
        read_mux = pll_divider_r;
      end else if (addr == `VCC_ADDR_PMUL) begin
        read_mux = pll_multiplier_r;
      end else if (addr == `VCC_ADDR_INGAIN) begin
        read_mux = input_gain_mute_r;
      end else if (addr == `VCC_ADDR_RXVOL) begin
        read_mux = receive_volume_r & `VCC_MASK_RXVOL;
      end else if (addr == `VCC_ADDR_TXVOL) begin
        read_mux = transmit_volume_r & `VCC_MASK_TXVOL;
      end else if (addr == `VCC_ADDR_SHORT) begin
        read_mux = short_latch_r & `VCC_MASK_SHORT;
      end else if (addr == `VCC_ADDR_ATTEN) begin
        read_mux = output_attenuation_r & `VCC_MASK_ATTEN;
      end else begin
        read_mux = 8'h00;
      end
    end
  endfunction

  always @* begin
    rd_data = read_mux(partial_r[4:0]);
  end

  vcc_frame_shift #(
    .FRAME_BITS (`VCC_FRAME_BITS)
  ) u_shift (
    .core_clk    (core_clk),
    .rst         (rst),
    .bit_en      (bit_en),
    .frame_start (frame_start),
    .ser_in      (ser_in),
    .load_data   (rd_data),
    .load_en     (addr_ready),
    .ser_out     (ser_out),
    .frame_word  (frame_word),
    .frame_done  (frame_done),
    .addr_ready  (addr_ready)
  );

  // frame layout: bit 15 spare, bit 13 high means read, 12:8 address, 7:0 data
  assign wr_strobe  = frame_done && !frame_word[13];
  assign wr_addr    = frame_word[12:8];
  assign wr_data    = frame_word[7:0];
  assign soft_reset = wr_strobe && (wr_addr == `VCC_ADDR_MAIN) && wr_data[`VCC_BIT_SOFT_RESET];

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_control_r            <= `VCC_RST_MAIN;
      filter_loopback_control_r <= `VCC_RST_FILT;
      pll_divider_r             <= `VCC_RST_PDIV;
      pll_multiplier_r          <= `VCC_RST_PMUL;
      input_gain_mute_r         <= `VCC_RST_INGAIN;
      receive_volume_r          <= `VCC_RST_RXVOL;
      transmit_volume_r         <= `VCC_RST_TXVOL;
      output_attenuation_r      <= `VCC_RST_ATTEN;
    end else if (!reset_pin_n || soft_reset) begin
      // soft reset bit is never stored, so it reads back cleared
      main_control_r            <= `VCC_RST_MAIN;
      filter_loopback_control_r <= `VCC_RST_FILT;
      pll_divider_r             <= `VCC_RST_PDIV;
      pll_multiplier_r          <= `VCC_RST_PMUL;
      input_gain_mute_r         <= `VCC_RST_INGAIN;
      receive_volume_r          <= `VCC_RST_RXVOL;
      transmit_volume_r         <= `VCC_RST_TXVOL;
      output_attenuation_r      <= `VCC_RST_ATTEN;
    end else if (wr_strobe) begin
      // address zero and undefined addresses fall through untouched
      if (wr_addr == `VCC_ADDR_MAIN) begin
        main_control_r <= wr_data & `VCC_MASK_MAIN;
      end else if (wr_addr == `VCC_ADDR_FILT) begin
        filter_loopback_control_r <= wr_data & `VCC_MASK_FILT;
      end else if (wr_addr == `VCC_ADDR_PDIV) begin
        pll_divider_r <= wr_data;
      end else if (wr_addr == `VCC_ADDR_PMUL) begin
        pll_multiplier_r <= wr_data;
      end else if (wr_addr == `VCC_ADDR_INGAIN) begin
        input_gain_mute_r <= wr_data;
      end else if (wr_addr == `VCC_ADDR_RXVOL) begin
        receive_volume_r <= wr_data & `VCC_MASK_RXVOL;
      end else if (wr_addr == `VCC_ADDR_TXVOL) begin
        transmit_volume_r <= wr_data & `VCC_MASK_TXVOL;
      end else if (wr_addr == `VCC_ADDR_ATTEN) begin
        output_attenuation_r <= wr_data & `VCC_MASK_ATTEN;
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      short_latch_r <= 8'h00;
    end else begin
      short_latch_r <= {short_status, 5'h00};
    end
  end

  // sleep latches on the sleep bit and holds until the reset pin is pulled low
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sleep_hold_r <= 1'b0;
    end else begin
      if (!reset_pin_n) begin
        sleep_hold_r <= 1'b0;
      end else if (main_control_r[`VCC_BIT_SLEEP]) begin
        sleep_hold_r <= 1'b1;
      end
    end
  end

  assign speaker_drive_on      = main_control_r[`VCC_BIT_SPK_ON];
  assign line_drive_on         = main_control_r[`VCC_BIT_LINE_ON];
  assign handset_drive_on      = main_control_r[`VCC_BIT_HSET_ON];
  assign mic_bias_off          = main_control_r[`VCC_BIT_MICB_OFF];
  assign chip_sleep            = sleep_hold_r | main_control_r[`VCC_BIT_SLEEP];
  assign highpass_disable      = filter_loopback_control_r[`VCC_BIT_HPF_DIS];
  assign analog_loopback_en    = filter_loopback_control_r[`VCC_BIT_ALOOP];
  assign bitstream_loopback_en = filter_loopback_control_r[`VCC_BIT_BLOOP];
  assign pll_div_value         = pll_divider_r;
  assign pll_mul_value         = pll_multiplier_r;
  assign line_in_gain          = input_gain_mute_r[7:6];
  assign line_in_mute          = input_gain_mute_r[5];
  assign mic_gain              = input_gain_mute_r[4:3];
  assign mic_mute              = input_gain_mute_r[2];
  assign handset_in_mute       = input_gain_mute_r[1];
  assign recursive_filter_sel  = input_gain_mute_r[0];
  assign receive_gain_code     = receive_volume_r[6:2];
  assign line_out_active       = receive_volume_r[1];
  assign handset_out_active    = receive_volume_r[0];
  assign transmit_volume       = transmit_volume_r & `VCC_MASK_TXVOL;
  assign output_attenuation    = output_attenuation_r;

  vcc_pll_ctrl u_pll (
    .div_value  (pll_divider_r),
    .mul_value  (pll_multiplier_r),
    .div10_sel  (filter_loopback_control_r[`VCC_BIT_DIV10]),
    .div_factor (pll_div_factor),
    .mul_factor (pll_mul_factor),
    .final_div  (pll_final_div),
    .pll_bypass (pll_bypass)
  );
endmodule // vcc_control_regs

// *** dv/vcc_regs_chk.sv ***
// port assertions for the codec control register bank
`timescale 1ns/100ps
module vcc_regs_chk (
  input logic       core_clk,
  input logic       rst,
  input logic       reset_pin_n,
  input logic       bit_en,
  input logic       frame_start,
  input logic       ser_out,
  input logic       chip_sleep,
  input logic       speaker_drive_on,
  input logic [7:0] pll_div_value,
  input logic [7:0] pll_mul_value,
  input logic [8:0] pll_div_factor,
  input logic [8:0] pll_mul_factor,
  input logic [3:0] pll_final_div,
  input logic       pll_bypass,
  input logic [1:0] line_in_gain,
  input logic       mic_mute,
  input logic       recursive_filter_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_pin_low; !reset_pin_n; endsequence
  // four idle cycles cover the one-cycle write latency
  sequence s_quiet; (reset_pin_n && !bit_en) [*4]; endsequence
  sequence s_first_bit; frame_start && bit_en; endsequence
  a_div_plus_one: assert property (pll_div_factor == pll_div_value + 9'h001)
    else $error("divider factor wrong");
  a_mul_plus_one: assert property (pll_mul_factor == pll_mul_value + 9'h001)
    else $error("multiplier factor wrong");
  a_bypass_both_zero: assert property (pll_bypass == (pll_div_value == 8'h00 && pll_mul_value == 8'h00))
    else $error("bypass select wrong");
  a_final_div_pair: assert property (pll_final_div == 4'hA || pll_final_div == 4'h5)
    else $error("final divide out of range");
  a_pin_defaults: assert property (s_pin_low |=> line_in_gain == 2'h1 && mic_mute && recursive_filter_sel)
    else $error("input gain not at default");
  a_pin_wakes: assert property (s_pin_low |=> !chip_sleep)
    else $error("sleep kept through reset pin");
  a_sleep_held: assert property (chip_sleep && reset_pin_n |=> chip_sleep)
    else $error("sleep left without reset pin");
  a_quiet_stable: assert property (s_quiet |-> $stable({pll_div_value, pll_mul_value, line_in_gain, speaker_drive_on}))
    else $error("setting changed outside a frame");
  a_start_out_low: assert property (s_first_bit |=> !ser_out)
    else $error("data out busy at frame start");
endmodule // vcc_regs_chk
bind vcc_control_regs vcc_regs_chk i_vcc_regs_chk (.*);

// *** dv/vcc_host_model.sv ***
// host side model sending secondary control frames
`timescale 1ns/100ps
module vcc_host_model (
  input  logic core_clk,
  input  logic ser_out,
  output logic bit_en,
  output logic frame_start,
  output logic ser_in
);
  initial begin
    bit_en = 1'b0;
    frame_start = 1'b0;
    ser_in = 1'b0;
  end
  // one access per frame; gap slows the bit rate
  task automatic xfer(input logic rw, input logic [4:0] a, input logic [7:0] d,
                      input int gap, output logic [7:0] q);
    logic [15:0] w;
    w = {2'b00, rw, a, d};
    q = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      bit_en = 1'b1;
      if (i == 15) frame_start = 1'b1;
      ser_in = w[i];
      @(posedge core_clk);
      #1;
      if (i < 8) q = {q[6:0], ser_out};
      if (i == 15) frame_start = 1'b0;
      // inverted level so a stale bit is never mistaken for data
      if (gap > 0 || i == 0) begin
        bit_en = 1'b0;
        ser_in = ~w[i];
      end
      repeat (gap) begin @(posedge core_clk); #1; end
    end
    repeat (2) begin @(posedge core_clk); #1; end
  endtask
endmodule // vcc_host_model

// *** dv/vcc_control_regs_bench.sv ***
// self-checking bench for the codec control register bank
`timescale 1ns/100ps
module vcc_control_regs_bench;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reset_pin_n = 1'b1;
  logic [2:0] short_status = 3'h0;
  logic       bit_en, frame_start, ser_in, ser_out, chip_sleep, pll_bypass;
  logic       speaker_drive_on, line_drive_on, handset_drive_on, mic_bias_off;
  logic       highpass_disable, analog_loopback_en, bitstream_loopback_en;
  logic       line_in_mute, mic_mute, handset_in_mute, recursive_filter_sel;
  logic       line_out_active, handset_out_active;
  logic [7:0] pll_div_value, pll_mul_value, transmit_volume, output_attenuation, q, d, s;
  logic [8:0] pll_div_factor, pll_mul_factor;
  logic [3:0] pll_final_div;
  logic [1:0] line_in_gain, mic_gain;
  logic [4:0] receive_gain_code;
  int         n_fail = 0;
  int         check_count = 0;
  int         a;
  int         wa[8] = '{1, 2, 3, 4, 5, 6, 7, 9};
  vcc_control_regs i_vcc_control_regs (.*);
  vcc_host_model i_vcc_host_model (.*);
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input int ad, input logic [7:0] v);
    i_vcc_host_model.xfer(1'b0, ad[4:0], v, $urandom_range(0, 2), q);
  endtask
  task rd(input int ad);
    i_vcc_host_model.xfer(1'b1, ad[4:0], 8'h00, $urandom_range(0, 2), q);
  endtask
  function automatic logic [7:0] rmask(input int ad);
    case (ad)
      1: return 8'h1F;
      2: return 8'h1E;
      3, 4, 5: return 8'hFF;
      6, 7: return 8'h7F;
      9: return 8'h0F;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] rdef(input int ad);
    case (ad)
      5: return 8'h47;
      6, 7: return 8'h5C;
      default: return 8'h00;
    endcase
  endfunction
  // register image rebuilt from the output pins
  function logic [7:0] pview(input int ad);
    case (ad)
      1: return {3'h0, speaker_drive_on, line_drive_on, handset_drive_on, mic_bias_off, chip_sleep};
      2: return {3'h0, highpass_disable, pll_final_div == 4'hA, analog_loopback_en, bitstream_loopback_en, 1'b0};
      3: return pll_div_value;
      4: return pll_mul_value;
      5: return {line_in_gain, line_in_mute, mic_gain, mic_mute, handset_in_mute, recursive_filter_sel};
      6: return {1'b0, receive_gain_code, line_out_active, handset_out_active};
      7: return transmit_volume;
      9: return output_attenuation;
      default: return 8'h00;
    endcase
  endfunction
  task end_sim;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    n_fail++;
    end_sim;
  end
  initial begin
    void'($urandom(95));
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    for (a = 0; a < 10; a++) begin
      rd(a);
      chk(q, rdef(a));
      chk(pview(a), rdef(a));
    end
    $display("reset values done");
    repeat (40) begin
      a = wa[$urandom_range(0, 7)];
      d = 8'($urandom) & rmask(a);
      if (a == 1) d[0] = 1'b0;
      if (a == 5 && d[7:6] == 2'h0) d[7:6] = 2'h1;
      wr(a, d);
      rd(a);
      chk(q, d);
      chk(pview(a), d);
    end
    foreach (wa[i]) begin
      d = 8'hFF & rmask(wa[i]);
      if (wa[i] == 1) d[0] = 1'b0;
      wr(wa[i], d);
      chk(pview(wa[i]), d);
    end
    $display("random access done");
    for (int v = 0; v < 2; v++) begin
      d = v ? 8'hFF : 8'h00;
      wr(3, d);
      wr(4, ~d);
      chk(pll_div_factor, {1'b0, d} + 9'h001);
      chk(pll_mul_factor, {1'b0, ~d} + 9'h001);
      wr(4, d);
      chk(pll_bypass, v == 0);
    end
    $display("pll done");
    s = pview(5);
    wr(0, 8'hFF);
    rd(0);
    chk(q, 8'h00);
    chk(pview(5), s);
    rd(5'h1F);
    chk(q, 8'h00);
    short_status = 3'($urandom);
    rd(8);
    chk(q, {short_status, 5'h00});
    $display("address zero and status done");
    wr(1, 8'h80);
    for (a = 1; a < 10; a++) if (a != 8) begin
      rd(a);
      chk(q, rdef(a));
    end
    $display("soft reset done");
    wr(1, 8'h01);
    chk(chip_sleep, 1'b1);
    wr(1, 8'h00);
    chk(chip_sleep, 1'b1);
    reset_pin_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 reset_pin_n = 1'b1;
    chk(chip_sleep, 1'b0);
    wr(6, 8'h03);
    rst = 1'b1;
    @(posedge core_clk);
    #1 rst = 1'b0;
    rd(6);
    chk(q, 8'h5C);
    $display("sleep and reset done");
    end_sim;
  end
endmodule // vcc_control_regs_bench
